// [common/tcp_regs.vh]
`ifndef TCP_REGS_VH
`define TCP_REGS_VH

// ---------------------------------------------------------------
// parameter record byte indices
// ---------------------------------------------------------------
`define TCP_IDX_FAULT_EN      4'h0
`define TCP_IDX_OPEN_EN       4'h1
`define TCP_IDX_TEMP_UNIT     4'h2
`define TCP_IDX_MAINS         4'h3
`define TCP_IDX_CH0_CODE      4'h4
`define TCP_IDX_CH1_CODE      4'h5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TCP_RST_FAULT_EN      8'h00
`define TCP_RST_OPEN_EN       8'h00
`define TCP_RST_TEMP_UNIT     8'h00
`define TCP_RST_MAINS         8'h02
`define TCP_RST_CH_CODE       8'hc1

// ---------------------------------------------------------------
// field positions and encodings
// ---------------------------------------------------------------
`define TCP_OPEN_CH0_BIT      0
`define TCP_OPEN_CH1_BIT      1
`define TCP_UNIT_C            2'h0
`define TCP_UNIT_F            2'h1
`define TCP_UNIT_K            2'h2
`define TCP_MAINS_60          2'h1
`define TCP_MAINS_50          2'h2

// ---------------------------------------------------------------
// range codes and scaling limits
// ---------------------------------------------------------------
`define TCP_CODE_MV_WIDE      8'h11
`define TCP_CODE_MV_NARROW    8'h21
`define TCP_CODE_OFF          8'hff
`define TCP_CODE_EXT_BASE     8'hb0
`define TCP_CODE_INT_BASE     8'hc0
`define TCP_CODE_TC_LAST      4'h9
`define TCP_WIDE_OVER         32'sd32511
`define TCP_WIDE_UNDER        -32'sd32512
`define TCP_NARROW_OVER       32'sd20480
`define TCP_NARROW_UNDER      -32'sd20480
`define TCP_TEMP_MAX          32'sd32767
`define TCP_TEMP_MIN          -32'sd32768
`define TCP_KELVIN_OFS        32'sd2732
`define TCP_FAHR_OFS          32'sd320

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TCP_CLK_KHZ           20000
`define TCP_CONV50_US         84200
`define TCP_CONV60_US         70500

`endif

// [design/tcp_chan.v]
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.vh"

module tcp_chan (
	input  wire        clock_i,   // system clock
	input  wire        sys_rst_i, // synchronous reset
	input  wire        load_i,    // conversion complete, take sample
	input  wire [7:0]  code_i,    // channel range code
	input  wire [1:0]  unit_i,    // temperature unit
	input  wire [19:0] mv_i,      // signed mV sample, 80 mV = 2^17
	input  wire [15:0] temp_i,    // signed 0.1 degC reading
	output reg  [15:0] value_o,   // formatted result word
	output reg         over_o,    // last result saturated high
	output reg         under_o    // last result saturated low
);

	// ---------------------------------------------------------------
	// combinational scaling
	// ---------------------------------------------------------------
	reg signed [31:0] x;      // widened sample
	reg signed [31:0] scaled; // unsaturated result
	reg signed [31:0] hi;     // upper limit for the code
	reg signed [31:0] lo;     // lower limit for the code

	// scale the sample according to range code and unit
	always @* begin
		x      = {{12{mv_i[19]}}, mv_i};
		scaled = 32'sd0;
		hi     = `TCP_TEMP_MAX;
		lo     = `TCP_TEMP_MIN;
		if (code_i == `TCP_CODE_MV_WIDE) begin
			// 27648 / 2^17 = 27 / 128
			scaled = ((x <<< 4) + (x <<< 3) + (x <<< 1) + x) >>> 7;
			hi     = `TCP_WIDE_OVER;
			lo     = `TCP_WIDE_UNDER;
		end else if (code_i == `TCP_CODE_MV_NARROW) begin
			// 16384 / 2^17 = 1 / 8
			scaled = x >>> 3;
			hi     = `TCP_NARROW_OVER;
			lo     = `TCP_NARROW_UNDER;
		end else begin
			// thermocouple codes: unit conversion of 0.1 degC value
			x = {{16{temp_i[15]}}, temp_i};
			if (unit_i == `TCP_UNIT_F) begin
				scaled = ((x * 32'sd9) / 32'sd5) + `TCP_FAHR_OFS;
			end else if (unit_i == `TCP_UNIT_K) begin
				scaled = x + `TCP_KELVIN_OFS;
			end else begin
				scaled = x;
			end
		end
	end

	// ---------------------------------------------------------------
	// saturating output register
	// ---------------------------------------------------------------
	// result only changes when a conversion of this channel completes
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			value_o <= 16'h0000;
			over_o  <= 1'b0;
			under_o <= 1'b0;
		end else if (load_i) begin
			if (scaled > hi) begin
				value_o <= hi[15:0];
				over_o  <= 1'b1;
				under_o <= 1'b0;
			end else if (scaled < lo) begin
				value_o <= lo[15:0];
				over_o  <= 1'b0;
				under_o <= 1'b1;
			end else begin
				value_o <= scaled[15:0];
				over_o  <= 1'b0;
				under_o <= 1'b0;
			end
		end
	end

endmodule // tcp_chan

`default_nettype wire

// [design/tcp_top.v]
// Functional notes
// - diagnostic byte switches diagnostic interrupt
// - wire-break bits 0/1 enable open-sensor detection
// - unit bits: 00 C, 01 F, 10 K
// - mains bits: 01 rejects 60Hz, 10 50Hz
// - range code selects range and format
// - range code FFh deactivates the channel
// - code 11h: 80mV=27648, clamp 32511/-32512
// - code 21h: 80mV=16384, clamp +/-20480
// - conversion 84.2ms at 50Hz, 70.5ms 60Hz
// - invalid parameters flag parameterization error
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.vh"

module tcp_top #(
	parameter [21:0] CONV50_CYC = (`TCP_CONV50_US * (`TCP_CLK_KHZ / 1000)),
	parameter [21:0] CONV60_CYC = (`TCP_CONV60_US * (`TCP_CLK_KHZ / 1000))
) (
	input  wire        clock_i,          // 20 MHz system clock
	input  wire        sys_rst_i,        // synchronous reset, active high
	input  wire        run_i,            // system in run state
	input  wire        param_wr_i,       // parameter byte write strobe
	input  wire [3:0]  param_idx_i,      // parameter byte index
	input  wire [7:0]  param_data_i,     // parameter byte value
	output reg  [7:0]  param_rd_data_o,  // byte at param_idx_i, one cycle later
	input  wire [19:0] ch0_mv_i,         // channel 0 signed mV sample
	input  wire [19:0] ch1_mv_i,         // channel 1 signed mV sample
	input  wire [15:0] ch0_temp_i,       // channel 0 linearised 0.1 degC
	input  wire [15:0] ch1_temp_i,       // channel 1 linearised 0.1 degC
	input  wire [1:0]  open_sensor_i,    // front end sees an open loop
	output wire [1:0]  open_detect_en_o, // open-sensor detection per channel
	output wire        mains_50hz_o,     // filter tuned for 50 Hz
	output wire        diag_irq_en_o,    // diagnostic interrupt enabled
	output reg  [1:0]  conv_busy_o,      // channel under conversion
	output reg  [1:0]  word_upd_o,       // pulse: channel word updated
	output wire [15:0] in_word0_o,       // channel 0 result word
	output wire [15:0] in_word1_o,       // channel 1 result word
	output reg         param_err_o,      // parameterization error
	output reg  [1:0]  chan_err_o,       // per-channel error indication
	output wire        module_err_o      // any error present
);

	// ---------------------------------------------------------------
	// parameter record
	// ---------------------------------------------------------------
	reg [7:0] fault_report_enable_reg;       // diagnostic enable byte
	reg [7:0] open_sensor_detect_enable_reg; // wire-break byte
	reg [7:0] temperature_unit_select_reg;   // unit byte
	reg [7:0] mains_reject_select_reg;       // mains rejection byte
	reg [7:0] channel0_range_code_reg;       // channel 0 range code
	reg [7:0] channel1_range_code_reg;       // channel 1 range code

	// writes; the enable bytes are refused while running
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			fault_report_enable_reg       <= `TCP_RST_FAULT_EN;
			open_sensor_detect_enable_reg <= `TCP_RST_OPEN_EN;
			temperature_unit_select_reg   <= `TCP_RST_TEMP_UNIT;
			mains_reject_select_reg       <= `TCP_RST_MAINS;
			channel0_range_code_reg       <= `TCP_RST_CH_CODE;
			channel1_range_code_reg       <= `TCP_RST_CH_CODE;
		end else if (param_wr_i) begin
			if (param_idx_i == `TCP_IDX_FAULT_EN && !run_i) begin
				fault_report_enable_reg <= param_data_i;
			end else if (param_idx_i == `TCP_IDX_OPEN_EN && !run_i) begin
				open_sensor_detect_enable_reg <= param_data_i;
			end else if (param_idx_i == `TCP_IDX_TEMP_UNIT) begin
				temperature_unit_select_reg <= param_data_i;
			end else if (param_idx_i == `TCP_IDX_MAINS) begin
				mains_reject_select_reg <= param_data_i;
			end else if (param_idx_i == `TCP_IDX_CH0_CODE) begin
				channel0_range_code_reg <= param_data_i;
			end else if (param_idx_i == `TCP_IDX_CH1_CODE) begin
				channel1_range_code_reg <= param_data_i;
			end
		end
	end

	// registered read-back, unknown indices read zero
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			param_rd_data_o <= 8'h00;
		end else if (param_idx_i == `TCP_IDX_FAULT_EN) begin
			param_rd_data_o <= fault_report_enable_reg;
		end else if (param_idx_i == `TCP_IDX_OPEN_EN) begin
			param_rd_data_o <= open_sensor_detect_enable_reg;
		end else if (param_idx_i == `TCP_IDX_TEMP_UNIT) begin
			param_rd_data_o <= temperature_unit_select_reg;
		end else if (param_idx_i == `TCP_IDX_MAINS) begin
			param_rd_data_o <= mains_reject_select_reg;
		end else if (param_idx_i == `TCP_IDX_CH0_CODE) begin
			param_rd_data_o <= channel0_range_code_reg;
		end else if (param_idx_i == `TCP_IDX_CH1_CODE) begin
			param_rd_data_o <= channel1_range_code_reg;
		end else begin
			param_rd_data_o <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// decoded settings
	// ---------------------------------------------------------------
	assign diag_irq_en_o    = (fault_report_enable_reg != 8'h00);
	assign open_detect_en_o = {open_sensor_detect_enable_reg[`TCP_OPEN_CH1_BIT],
	                           open_sensor_detect_enable_reg[`TCP_OPEN_CH0_BIT]};
	assign mains_50hz_o     = (mains_reject_select_reg[1:0] == `TCP_MAINS_50);

	// range code is one of the supported set
	function code_ok;
		input [7:0] code;
		begin
			code_ok = (code == `TCP_CODE_MV_WIDE) || (code == `TCP_CODE_MV_NARROW) ||
			          (code == `TCP_CODE_OFF) ||
			          ((code[7:4] == `TCP_CODE_EXT_BASE >> 4) && (code[3:0] <= `TCP_CODE_TC_LAST)) ||
			          ((code[7:4] == `TCP_CODE_INT_BASE >> 4) && (code[3:0] <= `TCP_CODE_TC_LAST));
		end
	endfunction

	wire       code0_ok = code_ok(channel0_range_code_reg);
	wire       code1_ok = code_ok(channel1_range_code_reg);
	wire       unit_ok  = (temperature_unit_select_reg[1:0] != 2'h3) &&
	                      (temperature_unit_select_reg[7:2] == 6'h00);
	wire       mains_ok = ((mains_reject_select_reg[1:0] == `TCP_MAINS_50) ||
	                       (mains_reject_select_reg[1:0] == `TCP_MAINS_60)) &&
	                      (mains_reject_select_reg[7:2] == 6'h00);
	wire       open_ok  = (open_sensor_detect_enable_reg[7:2] == 6'h00);
	// a channel converts only with a valid, non-off code
	wire [1:0] active   = {code1_ok && (channel1_range_code_reg != `TCP_CODE_OFF),
	                       code0_ok && (channel0_range_code_reg != `TCP_CODE_OFF)};

	// ---------------------------------------------------------------
	// conversion sequencer
	// ---------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001; // choose next channel
	localparam [2:0] ST_CONV = 3'b010; // conversion time running
	localparam [2:0] ST_LOAD = 3'b100; // result capture

	reg  [2:0]  state_reg;   // sequencer state
	reg  [2:0]  state_next;
	reg         ch_reg;      // channel being converted
	reg         ch_next;
	reg  [21:0] timer_reg;   // remaining conversion cycles
	reg  [21:0] timer_next;
	wire [21:0] conv_cyc = mains_50hz_o ? CONV50_CYC : CONV60_CYC;

	// next-state logic; channels alternate, inactive ones are skipped
	always @* begin
		state_next = state_reg;
		ch_next    = ch_reg;
		timer_next = timer_reg;
		case (state_reg)
			ST_IDLE: begin
				if (active[~ch_reg]) begin
					ch_next    = ~ch_reg;
					timer_next = conv_cyc - 22'd1;
					state_next = ST_CONV;
				end else if (active[ch_reg]) begin
					timer_next = conv_cyc - 22'd1;
					state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				if (!active[ch_reg]) begin
					// channel switched off mid-conversion: abandon it
					state_next = ST_IDLE;
				end else if (timer_reg == 22'd0) begin
					state_next = ST_LOAD;
				end else begin
					timer_next = timer_reg - 22'd1;
				end
			end
			ST_LOAD: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
			ch_reg    <= 1'b1;
			timer_reg <= 22'd0;
		end else begin
			state_reg <= state_next;
			ch_reg    <= ch_next;
			timer_reg <= timer_next;
		end
	end

	wire [1:0] load = (state_reg == ST_LOAD) ? {ch_reg, ~ch_reg} : 2'b00;

	// busy and update indications
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			conv_busy_o <= 2'b00;
			word_upd_o  <= 2'b00;
		end else begin
			conv_busy_o <= (state_next == ST_CONV) ? {ch_next, ~ch_next} : 2'b00;
			word_upd_o  <= load;
		end
	end

	// ---------------------------------------------------------------
	// per-channel formatting
	// ---------------------------------------------------------------
	wire [1:0] over;  // channel saturated high
	wire [1:0] under; // channel saturated low

	tcp_chan u_chan0 (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (load[0]),
		.code_i    (channel0_range_code_reg),
		.unit_i    (temperature_unit_select_reg[1:0]),
		.mv_i      (ch0_mv_i),
		.temp_i    (ch0_temp_i),
		.value_o   (in_word0_o),
		.over_o    (over[0]),
		.under_o   (under[0])
	);

	tcp_chan u_chan1 (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (load[1]),
		.code_i    (channel1_range_code_reg),
		.unit_i    (temperature_unit_select_reg[1:0]),
		.mv_i      (ch1_mv_i),
		.temp_i    (ch1_temp_i),
		.value_o   (in_word1_o),
		.over_o    (over[1]),
		.under_o   (under[1])
	);

	// ---------------------------------------------------------------
	// error indication
	// ---------------------------------------------------------------
	// parameter error and channel faults, recomputed every cycle
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			param_err_o <= 1'b0;
			chan_err_o  <= 2'b00;
		end else begin
			param_err_o <= !(code0_ok && code1_ok && unit_ok && mains_ok && open_ok);
			chan_err_o  <= {!code1_ok, !code0_ok} |
			               (active & (over | under)) |
			               (active & open_detect_en_o & open_sensor_i);
		end
	end

	assign module_err_o = param_err_o || (chan_err_o != 2'b00);

endmodule // tcp_top

`default_nettype wire

// [dv/tcp_reader.sv]
`timescale 1ns/1ps
`default_nettype none
// process-data reader: latches each word on its update pulse
module tcp_reader (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic [1:0]  word_upd_i,
	input  wire logic [15:0] word0_i,
	input  wire logic [15:0] word1_i,
	output var  logic [15:0] last0_o,
	output var  logic [15:0] last1_o,
	output var  logic [7:0]  cnt0_o,
	output var  logic [7:0]  cnt1_o
);
	// word slots keep channel 0 first, channel 1 second
	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			last0_o <= 16'h0000;
			last1_o <= 16'h0000;
			cnt0_o  <= 8'h00;
			cnt1_o  <= 8'h00;
		end else begin
			if (word_upd_i[0]) begin
				last0_o <= word0_i;
				cnt0_o  <= cnt0_o + 8'h01;
			end
			if (word_upd_i[1]) begin
				last1_o <= word1_i;
				cnt1_o  <= cnt1_o + 8'h01;
			end
		end
	end
endmodule // tcp_reader
`default_nettype wire

// [dv/tcp_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module tcp_top_props (
	input wire logic        clock_i,
	input wire logic        sys_rst_i,
	input wire logic        run_i,
	input wire logic        param_wr_i,
	input wire logic [3:0]  param_idx_i,
	input wire logic [7:0]  param_data_i,
	input wire logic [1:0]  open_detect_en_o,
	input wire logic        mains_50hz_o,
	input wire logic        diag_irq_en_o,
	input wire logic [1:0]  conv_busy_o,
	input wire logic [1:0]  word_upd_o,
	input wire logic [15:0] in_word0_o,
	input wire logic        param_err_o,
	input wire logic [1:0]  chan_err_o,
	input wire logic        module_err_o
);
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	logic       ch1_off_reg; // channel 1 code is all ones
	wire  [1:0] data_lo = param_data_i[1:0];
	wire        data_nz = |param_data_i;
	always_ff @(posedge clock_i) begin
		if (sys_rst_i)
			ch1_off_reg <= 1'b0;
		else if (param_wr_i && param_idx_i == 4'h5)
			ch1_off_reg <= (param_data_i == 8'hff);
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_off3;
		ch1_off_reg [*3];
	endsequence
	sequence s_open_wr;
		param_wr_i && param_idx_i == 4'h1;
	endsequence
	// channel 1 given a code outside the supported set
	sequence s_bad_code;
		param_wr_i && param_idx_i == 4'h5 && param_data_i == 8'h55;
	endsequence
	AST_RST_VALS: assert property ($past(sys_rst_i) |-> mains_50hz_o && !diag_irq_en_o && open_detect_en_o == 2'h0)
		else $error("reset values wrong");
	AST_MAINS_60: assert property (param_wr_i && param_idx_i == 4'h3 && param_data_i == 8'h01 |=> !mains_50hz_o)
		else $error("60 Hz select lost");
	AST_MAINS_50: assert property (param_wr_i && param_idx_i == 4'h3 && param_data_i == 8'h02 |=> mains_50hz_o)
		else $error("50 Hz select lost");
	AST_OPEN_EN: assert property (s_open_wr ##0 !run_i |=> open_detect_en_o == $past(data_lo))
		else $error("open detect enable wrong");
	AST_OPEN_HOLD: assert property (s_open_wr ##0 run_i |=> $stable(open_detect_en_o))
		else $error("enable byte taken in run");
	AST_DIAG: assert property (param_wr_i && param_idx_i == 4'h0 && !run_i |=> diag_irq_en_o == $past(data_nz))
		else $error("diag enable wrong");
	AST_UPD_PULSE: assert property (word_upd_o[0] |=> !word_upd_o[0])
		else $error("update pulse too long");
	AST_WORD_CAUSE: assert property ($changed(in_word0_o) |-> word_upd_o[0])
		else $error("word changed without update");
	AST_CH_OFF: assert property (s_off3 |-> !conv_busy_o[1])
		else $error("disabled channel converts");
	AST_ERR_OR: assert property (module_err_o == (param_err_o || chan_err_o != 2'h0))
		else $error("module error mismatch");
	AST_PARAM_ERR: assert property (s_bad_code |=> ##1 param_err_o)
		else $error("bad range code not flagged");
endmodule // tcp_top_props
bind tcp_top tcp_top_props u_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .run_i(run_i),
	.param_wr_i(param_wr_i), .param_idx_i(param_idx_i), .param_data_i(param_data_i),
	.open_detect_en_o(open_detect_en_o), .mains_50hz_o(mains_50hz_o), .diag_irq_en_o(diag_irq_en_o),
	.conv_busy_o(conv_busy_o), .word_upd_o(word_upd_o), .in_word0_o(in_word0_o),
	.param_err_o(param_err_o), .chan_err_o(chan_err_o), .module_err_o(module_err_o));
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
	$display("wrong value %s expected %0h seen %0h", n, e, s); end end
module tb;
	logic clock_i = 0, sys_rst_i = 1, run_i = 0, param_wr_i = 0;
	logic [3:0]  param_idx_i = 0;
	logic [7:0]  param_data_i = 0, param_rd_data_o, cnt0, cnt1;
	logic [19:0] ch0_mv_i = 0, ch1_mv_i = 0;
	logic [15:0] ch0_temp_i = 0, ch1_temp_i = 16'h0123, in_word0_o, in_word1_o, last0, last1;
	logic [1:0]  open_sensor_i = 0, open_detect_en_o, conv_busy_o, word_upd_o, chan_err_o, u;
	logic        mains_50hz_o, diag_irq_en_o, param_err_o, module_err_o;
	int fail_count = 0, cmp_count = 0, p50, p60;
	always #25 clock_i = ~clock_i;
	tcp_top #(.CONV50_CYC(22'd20), .CONV60_CYC(22'd16)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.run_i(run_i), .param_wr_i(param_wr_i), .param_idx_i(param_idx_i), .param_data_i(param_data_i),
		.param_rd_data_o(param_rd_data_o), .ch0_mv_i(ch0_mv_i), .ch1_mv_i(ch1_mv_i), .ch0_temp_i(ch0_temp_i),
		.ch1_temp_i(ch1_temp_i), .open_sensor_i(open_sensor_i), .open_detect_en_o(open_detect_en_o),
		.mains_50hz_o(mains_50hz_o), .diag_irq_en_o(diag_irq_en_o), .conv_busy_o(conv_busy_o),
		.word_upd_o(word_upd_o), .in_word0_o(in_word0_o), .in_word1_o(in_word1_o),
		.param_err_o(param_err_o), .chan_err_o(chan_err_o), .module_err_o(module_err_o));
	tcp_reader rdr (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .word_upd_i(word_upd_o), .word0_i(in_word0_o),
		.word1_i(in_word1_o), .last0_o(last0), .last1_o(last1), .cnt0_o(cnt0), .cnt1_o(cnt1));
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one parameter byte, strobe held for one edge
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		@(posedge clock_i);
		#2 param_wr_i = 1; param_idx_i = i; param_data_i = d;
		@(posedge clock_i);
		#2 param_wr_i = 0;
	endtask
	task automatic wait_any(output logic [1:0] f);
		int n;
		n = 0;
		do begin @(posedge clock_i); #1 n++; end while (word_upd_o == 2'h0 && n < 200);
		if (n >= 200) `CHK("update timeout", 1, 0)
		f = word_upd_o;
	endtask
	task automatic wait_upd(input int c);
		logic [1:0] f;
		do wait_any(f); while (f[c] !== 1'b1 && fail_count == 0);
	endtask
	task automatic t_reset;
		logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'hc1, 8'hc1};
		for (int i = 0; i < 7; i++) begin
			@(posedge clock_i); #2 param_idx_i = i;
			@(posedge clock_i); #1 `CHK("readback", (i < 6) ? rv[i] : 8'h00, param_rd_data_o)
		end
		$display("test reset done");
	endtask
	task automatic t_params;
		wr(1, 8'h03); `CHK("open en", 2'h3, open_detect_en_o)
		run_i = 1; wr(1, 8'h00); wr(0, 8'h01);
		`CHK("open en run", 2'h3, open_detect_en_o)
		`CHK("diag run", 1'b0, diag_irq_en_o)
		run_i = 0; wr(0, 8'h01); `CHK("diag on", 1'b1, diag_irq_en_o)
		wr(0, 8'h00); `CHK("diag off", 1'b0, diag_irq_en_o)
		wr(3, 8'h01); `CHK("mains 60", 1'b0, mains_50hz_o)
		wr(3, 8'h02); `CHK("mains 50", 1'b1, mains_50hz_o)
		wr(5, 8'h55); repeat (2) @(posedge clock_i); #1 `CHK("param err", 1'b1, param_err_o)
		wr(5, 8'hff); repeat (2) @(posedge clock_i); #1 `CHK("param ok", 1'b0, param_err_o)
		$display("test params done");
	endtask
	task automatic mv(input logic [7:0] c, input logic [19:0] x, input logic [15:0] e);
		wr(4, c); ch0_mv_i = x;
		wait_upd(0); wait_upd(0);
		`CHK("mv word", e, in_word0_o)
	endtask
	task automatic unit(input logic [1:0] un, input logic [15:0] e);
		wr(2, {6'h00, un});
		// read-back is registered: the new byte shows one edge after the write
		@(posedge clock_i); #1 `CHK("unit byte", {6'h00, un}, param_rd_data_o)
		wait_upd(0); wait_upd(0);
		`CHK("temp word", e, in_word0_o)
	endtask
	task automatic t_format;
		mv(8'h11, 20'h20000, 16'h6c00);
		mv(8'h11, 20'h30d40, 16'h7eff);
		mv(8'h11, 20'he0000, 16'h9400);
		mv(8'h11, 20'hcf2c0, 16'h8100);
		mv(8'h21, 20'h20000, 16'h4000);
		mv(8'h21, 20'h30d40, 16'h5000);
		mv(8'h21, 20'hcf2c0, 16'hb000);
		wr(4, 8'hc1); ch0_temp_i = 16'h03e8;
		unit(2'h0, 16'h03e8);
		unit(2'h1, 16'h0848);
		unit(2'h2, 16'h0e94);
		$display("test format done");
	endtask
	task automatic period(output int p);
		wait_upd(0); wait_upd(0);
		p = 0;
		do begin @(posedge clock_i); #1 p++; end while (!word_upd_o[0] && p < 200);
	endtask
	task automatic t_timing;
		wr(3, 8'h02); period(p50);
		wr(3, 8'h01); period(p60);
		`CHK("period 50", 32'sd22, p50)
		`CHK("period gap", 32'sd4, p50 - p60)
		$display("test timing done");
	endtask
	task automatic t_order;
		logic [7:0] c0;
		wr(5, 8'hc1); wait_upd(0);
		wait_any(u); `CHK("next ch", 2'h2, u)
		wait_any(u); `CHK("next ch", 2'h1, u)
		wr(4, 8'hff); wait_upd(1); c0 = cnt0;
		wait_upd(1); wait_upd(1);
		`CHK("off count", c0, cnt0)
		`CHK("ch1 word", 16'h0bcf, last1)
		$display("test order done");
	endtask
	// open sensor and error outputs, then a reset in mid-run
	task automatic t_err;
		@(posedge clock_i); #2 open_sensor_i = 2'h3;
		@(posedge clock_i); #1 `CHK("chan err", 2'h2, chan_err_o)
		`CHK("module err", 1'b1, module_err_o)
		wr(1, 8'h00); @(posedge clock_i); #1 `CHK("chan err off", 2'h0, chan_err_o)
		`CHK("module err off", 1'b0, module_err_o)
		@(posedge clock_i); #2 sys_rst_i = 1;
		repeat (2) @(posedge clock_i);
		#2 sys_rst_i = 0;
		@(posedge clock_i); #1 `CHK("busy after reset", 2'h1, conv_busy_o)
		`CHK("mains after reset", 1'b1, mains_50hz_o)
		`CHK("word1 after reset", 16'h0000, in_word1_o)
		$display("test errors done");
	endtask
	initial begin
		#(50 * 20000);
		fail_count++;
		close_out;
	end
	initial begin
		repeat (3) @(posedge clock_i);
		#2 sys_rst_i = 0;
		t_reset;
		t_params;
		t_format;
		t_timing;
		t_order;
		t_err;
		close_out;
	end
endmodule // tb
`default_nettype wire
